//--- host_event_pkg.sv
`default_nettype none
package host_event_pkg;
  // ----------------------------------------------------------------
  // Command codes (bit 7 set means write)
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_STATE_RD = 8'h02;
  localparam logic [7:0] CMD_FLAGS_RD = 8'h03;
  localparam logic [7:0] CMD_FLAGS_WR = 8'h83;
  localparam logic [7:0] CMD_MASK_RD = 8'h04;
  localparam logic [7:0] CMD_MASK_WR = 8'h84;
  localparam logic [7:0] CMD_MASK_CLR_RD = 8'h05;
  localparam logic [7:0] CMD_MASK_CLR_WR = 8'h85;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FLAG_W = 7;
  localparam int BIT_OVERRUN = 0;
  localparam int BIT_FRAME_BEGIN = 2;
  localparam int BIT_RESUME = 3;
  localparam int BIT_FAULT = 4;
  localparam int BIT_WRAP = 5;
  localparam int BIT_PORT_CHANGE = 6;
  localparam int BIT_GATE = 31;
  localparam int FRAME_MSB = 15;
  localparam int FRAME_W = 16;
  localparam int SOC_LSB = 16;
  localparam int SOC_W = 2;
  localparam int PORT_STATE_W = 32;

  // Enable bits that software may touch (bit 1 reserved)
  localparam logic [6:0] MASK_WRITABLE = 7'h7d;
  // Flags that hardware can ever set (fault and bit 1 stay zero)
  localparam logic [6:0] FLAG_IMPL = 7'h6d;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [6:0] FLAGS_RST = 7'h00;
  localparam logic [6:0] MASK_RST = 7'h00;
  localparam logic GATE_RST = 1'b0;
  localparam logic [1:0] SOC_RST = 2'h0;
  localparam logic [31:0] RD_RST = 32'h0000_0000;
endpackage
`default_nettype wire

//--- host_event_status_and_mask.sv
`default_nettype none
module host_event_status_and_mask
  import host_event_pkg::*;
#(
  parameter int NUM_PORTS = 2
) (
  input wire logic clk,                                   // 25 MHz clock
  input wire logic reset_n,                               // Sync reset, active low
  input wire logic cmd_valid,                             // Command strobe, one cycle
  input wire logic [7:0] cmd_code,                        // Command code
  input wire logic [31:0] cmd_wdata,                      // Write data
  output logic [31:0] rd_data,                            // Read data, registered
  output logic rd_valid,                                  // Read answer strobe
  input wire logic [NUM_PORTS*PORT_STATE_W-1:0] root_port_state, // Port status bits
  input wire logic [FRAME_W-1:0] frame_index,             // Frame number counter
  input wire logic device_resume,                         // Resume signaling from device
  input wire logic resume_state_sw,                       // Software put us in resume state
  input wire logic frame_start,                           // Start of frame pulse
  input wire logic schedule_overrun,                      // Overrun pulse
  output logic sof_token,                                 // Start-of-frame token request
  output logic [SOC_W-1:0] overrun_count,                 // Overrun counter
  output logic irq_req                                    // Interrupt request, high
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Write data field when the given code is on the command port
  function automatic logic [6:0] wr_bits(input logic v, input logic [7:0] code,
                                         input logic [7:0] want, input logic [31:0] d);
    wr_bits = (v && code == want) ? d[6:0] : 7'h00;
  endfunction

  function automatic logic wr_bit31(input logic v, input logic [7:0] code,
                                    input logic [7:0] want, input logic [31:0] d);
    wr_bit31 = v && code == want && d[BIT_GATE];
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [6:0] flags_reg;
  logic [6:0] flags_next;
  logic [6:0] mask_reg;
  logic [6:0] mask_next;
  logic gate_reg;
  logic gate_next;
  logic [SOC_W-1:0] soc_reg;
  logic [NUM_PORTS*PORT_STATE_W-1:0] port_prev_reg;
  logic frame_msb_prev_reg;
  logic resume_prev_reg;
  logic primed_reg;
  logic sof_reg;
  logic [31:0] rd_data_reg;
  logic rd_valid_reg;
  logic [6:0] hw_set;
  logic [6:0] sw_clr;
  logic [6:0] en_set;
  logic [6:0] en_clr;
  logic port_changed;
  logic frame_wrapped;
  logic resume_rise;

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  // Edge detectors are held off for one cycle after reset so the
  // first sample of the inputs is not mistaken for a change.
  assign port_changed = primed_reg && (root_port_state != port_prev_reg);
  assign frame_wrapped = primed_reg && (frame_index[FRAME_MSB] != frame_msb_prev_reg);
  // Only a device-driven rise counts, not software's own resume
  assign resume_rise = primed_reg && device_resume && !resume_prev_reg
                       && !resume_state_sw;

  // Set vector; fault source is never raised here
  always_comb begin
    hw_set = 7'h00;
    hw_set[BIT_PORT_CHANGE] = port_changed;
    hw_set[BIT_WRAP] = frame_wrapped;
    hw_set[BIT_RESUME] = resume_rise;
    hw_set[BIT_FRAME_BEGIN] = frame_start;
    hw_set[BIT_OVERRUN] = schedule_overrun;
  end

  // Previous-value samples
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port_prev_reg <= '0;
      frame_msb_prev_reg <= 1'b0;
      resume_prev_reg <= 1'b0;
      primed_reg <= 1'b0;
    end else begin
      port_prev_reg <= root_port_state;
      frame_msb_prev_reg <= frame_index[FRAME_MSB];
      resume_prev_reg <= device_resume;
      primed_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  assign sw_clr = wr_bits(cmd_valid, cmd_code, CMD_FLAGS_WR, cmd_wdata);
  // Set wins over a clear in the same cycle so no event is lost;
  // software can only remove bits, never add them.
  assign flags_next = ((flags_reg & ~sw_clr) | hw_set) & FLAG_IMPL;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flags_reg <= FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ----------------------------------------------------------------
  // Enables and global gate
  // ----------------------------------------------------------------
  assign en_set = wr_bits(cmd_valid, cmd_code, CMD_MASK_WR, cmd_wdata);
  assign en_clr = wr_bits(cmd_valid, cmd_code, CMD_MASK_CLR_WR, cmd_wdata);
  assign mask_next = ((mask_reg | en_set) & ~en_clr) & MASK_WRITABLE;
  assign gate_next = (gate_reg | wr_bit31(cmd_valid, cmd_code, CMD_MASK_WR, cmd_wdata))
                     & !wr_bit31(cmd_valid, cmd_code, CMD_MASK_CLR_WR, cmd_wdata);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mask_reg <= MASK_RST;
      gate_reg <= GATE_RST;
    end else begin
      mask_reg <= mask_next;
      gate_reg <= gate_next;
    end
  end

  // ----------------------------------------------------------------
  // Overrun counter and frame token
  // ----------------------------------------------------------------
  // Counts every overrun regardless of the flag; wraps naturally
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      soc_reg <= SOC_RST;
    end else if (schedule_overrun) begin
      soc_reg <= soc_reg + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sof_reg <= 1'b0;
    end else begin
      sof_reg <= frame_start;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Any code without bit 7 answers next cycle; unknown codes read zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_data_reg <= RD_RST;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= cmd_valid && !cmd_code[7];
      rd_data_reg <= RD_RST;
      if (cmd_valid) begin
        case (cmd_code)
          CMD_FLAGS_RD: rd_data_reg <= {25'h0, flags_reg};
          CMD_MASK_RD, CMD_MASK_CLR_RD: begin
            rd_data_reg <= {gate_reg, 24'h0, mask_reg};
          end
          CMD_STATE_RD: rd_data_reg <= {14'h0, soc_reg, 16'h0};
          default: rd_data_reg <= RD_RST;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
  assign sof_token = sof_reg;
  assign overrun_count = soc_reg;
  // Level built from registers only, so it cannot glitch on writes
  assign irq_req = gate_reg && |(flags_reg & mask_reg);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_FLAG_STICKY: assert property (
    (flags_reg != 7'h00) && !(cmd_valid && cmd_code == CMD_FLAGS_WR)
    |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg)))
    else $error("status flag lost without a clear write");

  AST_IRQ_CAUSE: assert property (
    $rose(irq_req) |-> $past(cmd_valid && cmd_code == CMD_MASK_WR) || $past(hw_set != 7'h00))
    else $error("interrupt rose without enable write or event");

  AST_W1C_CLEAR: assert property (
    cmd_valid && cmd_code == CMD_FLAGS_WR && cmd_wdata[BIT_FRAME_BEGIN] && !frame_start
    |=> !flags_reg[BIT_FRAME_BEGIN])
    else $error("write one did not clear flag");

  AST_NO_SW_SET: assert property (
    cmd_valid && cmd_code == CMD_FLAGS_WR && hw_set == 7'h00
    |=> (flags_reg & ~$past(flags_reg)) == 7'h00)
    else $error("software write set a flag");

  AST_PORT_CHANGE: assert property (
    primed_reg && root_port_state != $past(root_port_state) |=> flags_reg[BIT_PORT_CHANGE])
    else $error("port change flag not set");

  AST_FRAME_WRAP: assert property (
    primed_reg && $changed(frame_index[FRAME_MSB]) |=> flags_reg[BIT_WRAP])
    else $error("frame wrap flag not set");

  AST_FAULT_ZERO: assert property (
    !flags_reg[BIT_FAULT] && !flags_reg[1])
    else $error("fault or reserved flag set");

  AST_RESUME_SET: assert property (
    primed_reg && $rose(device_resume) && !resume_state_sw |=> flags_reg[BIT_RESUME])
    else $error("resume flag not set");

  AST_RESUME_SW: assert property (
    $rose(flags_reg[BIT_RESUME]) |-> $past(device_resume && !resume_state_sw))
    else $error("resume flag set by software resume");

  AST_SOF: assert property (
    frame_start |=> sof_token && flags_reg[BIT_FRAME_BEGIN])
    else $error("frame start not flagged");

  AST_OVERRUN: assert property (
    schedule_overrun |=> flags_reg[BIT_OVERRUN]
    && overrun_count == 2'($past(overrun_count) + 2'h1))
    else $error("overrun not flagged or counted");

  AST_MASK_SET: assert property (
    cmd_valid && cmd_code == CMD_MASK_WR
    |=> (mask_reg & $past(cmd_wdata[6:0]) & MASK_WRITABLE) == ($past(cmd_wdata[6:0]) & MASK_WRITABLE))
    else $error("enable write did not set bits");

  AST_MASK_READ: assert property (
    cmd_valid && cmd_code == CMD_MASK_RD
    |=> rd_valid && rd_data == {$past(gate_reg), 24'h0, $past(mask_reg)} && !rd_data[1])
    else $error("enable read mismatch");

  AST_GATE_SET: assert property (
    cmd_valid && cmd_code == CMD_MASK_WR && cmd_wdata[BIT_GATE] |=> gate_reg)
    else $error("global gate not set");

  AST_MASK_CLR: assert property (
    cmd_valid && cmd_code == CMD_MASK_CLR_WR && cmd_wdata[BIT_OVERRUN]
    |=> !mask_reg[BIT_OVERRUN] ##1 !mask_reg[BIT_OVERRUN] || $past(cmd_code == CMD_MASK_WR))
    else $error("disable write did not clear enable");

  AST_IRQ_DROP: assert property (
    cmd_valid && cmd_code == CMD_FLAGS_WR && cmd_wdata[6:0] == 7'h7f && hw_set == 7'h00
    |=> !irq_req)
    else $error("interrupt held after all flags cleared");

  AST_GATE_CLR: assert property (
    cmd_valid && cmd_code == CMD_MASK_CLR_WR && cmd_wdata[BIT_GATE] |=> !gate_reg && !irq_req)
    else $error("gate clear did not drop interrupt");

  // ----------------------------------------------------------------
  // Zero bits of a write leave state alone
  // ----------------------------------------------------------------
  // A decode slip here would silently wipe software's settings
  AST_W1C_KEEP: assert property (
    cmd_valid && cmd_code == CMD_FLAGS_WR
    |=> ($past(flags_reg) & ~$past(cmd_wdata[6:0]) & ~flags_reg) == 7'h00)
    else $error("write zero cleared a flag");

  AST_MASK_KEEP: assert property (
    cmd_valid && cmd_code == CMD_MASK_WR |=> ($past(mask_reg) & ~mask_reg) == 7'h00)
    else $error("enable write cleared a bit");

  AST_DIS_KEEP: assert property (
    cmd_valid && cmd_code == CMD_MASK_CLR_WR
    |=> ($past(mask_reg) & ~$past(cmd_wdata[6:0]) & ~mask_reg) == 7'h00
    && (mask_reg & ~$past(mask_reg)) == 7'h00)
    else $error("disable write touched other enables");

  AST_GATE_ZERO: assert property (
    cmd_valid && cmd_code == CMD_MASK_WR && !cmd_wdata[BIT_GATE] |=> gate_reg == $past(gate_reg))
    else $error("zero write changed global gate");

  // ----------------------------------------------------------------
  // Read-back, counter and frame token
  // ----------------------------------------------------------------
  AST_RSVD_ZERO: assert property (
    !mask_reg[1] && rd_data[15:7] == 9'h000 && rd_data[30:18] == 13'h0000)
    else $error("reserved bit not zero");

  AST_FLAGS_READ: assert property (
    cmd_valid && cmd_code == CMD_FLAGS_RD
    |=> rd_valid && rd_data == {25'h0, $past(flags_reg)} && !rd_data[BIT_FAULT])
    else $error("status read mismatch");

  AST_COUNT_READ: assert property (
    cmd_valid && cmd_code == CMD_STATE_RD |=> rd_data == {14'h0, $past(overrun_count), 16'h0})
    else $error("overrun count read mismatch");

  AST_COUNT_HOLD: assert property (
    !schedule_overrun |=> $stable(overrun_count))
    else $error("overrun count moved without overrun");

  AST_SOF_PULSE: assert property (
    !frame_start |=> !sof_token)
    else $error("frame token without frame start");

  // Main scenarios worth seeing in a run
  COV_IRQ: cover property (!irq_req ##1 irq_req);
  COV_IRQ_DROP: cover property (irq_req ##1 !irq_req);
  COV_SOC_WRAP: cover property (overrun_count == 2'h3 && schedule_overrun);
  COV_RESUME: cover property (resume_rise);
  COV_SET_CLEAR_SAME: cover property (frame_start && cmd_valid && cmd_code == CMD_FLAGS_WR);

endmodule
`default_nettype wire

//--- host_bus_model.sv
`default_nettype none
module host_bus_model (
  input wire logic clk,              // Bus clock
  output logic cmd_valid,            // Command strobe
  output logic [7:0] cmd_code,       // Command code
  output logic [31:0] cmd_wdata,     // Write data
  input wire logic [31:0] rd_data,   // Read answer
  input wire logic rd_valid          // Read answer strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Idle bus at time zero
  // ----------------------------------------------------------------
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 32'h0000_0000;
  end

  // One command per call; data inverted after release so stale values never match
  task automatic issue(input logic [7:0] code, input logic [31:0] d);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_wdata = d;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_code = ~code;
    cmd_wdata = ~d;
  endtask

  // Write: effect visible once the taking edge has passed
  task automatic wr(input logic [7:0] code, input logic [31:0] d);
    issue(code, d);
  endtask

  // Read: answer stands in the cycle after the taking edge
  task automatic rd(input logic [7:0] code, output logic [31:0] q, output logic ok);
    issue(code, 32'h0000_0000);
    q = rd_data;
    ok = rd_valid;
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
`default_nettype none
module testbench import host_event_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, reset_n, cmd_valid, rd_valid, device_resume, resume_state_sw;
  logic frame_start, schedule_overrun, sof_token, irq_req;
  logic [7:0] cmd_code;
  logic [31:0] cmd_wdata, rd_data;
  logic [63:0] root_port_state;
  logic [15:0] frame_index;
  logic [1:0] overrun_count, soc;
  int err_count = 0;
  int checks_done = 0;
  int sof_n = 0;
  localparam int BITPOS [5] = '{BIT_PORT_CHANGE, BIT_WRAP, BIT_RESUME, BIT_FRAME_BEGIN, BIT_OVERRUN};

  host_event_status_and_mask i_host_event_status_and_mask (.clk(clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data),
    .rd_valid(rd_valid), .root_port_state(root_port_state), .frame_index(frame_index),
    .device_resume(device_resume), .resume_state_sw(resume_state_sw), .frame_start(frame_start),
    .schedule_overrun(schedule_overrun), .sof_token(sof_token), .overrun_count(overrun_count),
    .irq_req(irq_req));
  host_bus_model i_host_bus_model (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid));

  // ----------------------------------------------------------------
  // Clock, token counter, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Counted rather than sampled, so the exact token cycle does not matter
  always @(posedge clk) if (sof_token === 1'b1) sof_n <= sof_n + 1;

  // Tests take well under 1000 cycles
  initial begin
    #(40 * 3000);
    err_count++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rchk(input string what, input logic [7:0] code, input logic [31:0] exp);
    logic [31:0] q;
    logic ok;
    i_host_bus_model.rd(code, q, ok);
    check({what, " valid"}, {31'h0, ok}, 32'h1);
    check(what, q, exp);
  endtask

  // Fire one event kind, then let the flag settle
  task automatic ev(input int k);
    @(negedge clk);
    case (k)
      0: root_port_state[40] = ~root_port_state[40];
      1: frame_index[15] = ~frame_index[15];
      2: device_resume = 1'b1;
      3: frame_start = 1'b1;
      default: begin
        schedule_overrun = 1'b1;
        soc = soc + 2'h1;
      end
    endcase
    @(negedge clk);
    frame_start = 1'b0;
    schedule_overrun = 1'b0;
    device_resume = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {reset_n, device_resume, resume_state_sw, frame_start, schedule_overrun} = 5'h00;
    root_port_state = 64'h0;
    frame_index = 16'h0;
    soc = 2'h0;
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    rchk("flags rst", CMD_FLAGS_RD, 32'h0);
    rchk("mask rst", CMD_MASK_RD, 32'h0);
    rchk("count rst", CMD_STATE_RD, 32'h0);
    rchk("unmapped rd", 8'h07, 32'h0);
    $display("test reset done");
    i_host_bus_model.wr(CMD_MASK_WR, 32'hffff_ffff);
    rchk("mask set", CMD_MASK_RD, {1'b1, 24'h0, MASK_WRITABLE});
    i_host_bus_model.wr(CMD_MASK_WR, 32'h0);
    i_host_bus_model.wr(CMD_MASK_CLR_WR, 32'h0);
    i_host_bus_model.wr(8'h8f, 32'h0);
    rchk("mask hold", CMD_MASK_CLR_RD, {1'b1, 24'h0, MASK_WRITABLE});
    i_host_bus_model.wr(CMD_MASK_CLR_WR, 32'h8000_0001);
    rchk("mask clr", CMD_MASK_RD, {25'h0, MASK_WRITABLE & 7'h7e});
    $display("test mask done");
    for (int k = 0; k < 10; k++) begin
      ev(k % 5);
      rchk("flag set", CMD_FLAGS_RD, 32'h1 << BITPOS[k % 5]);
      check("irq gated", {31'h0, irq_req}, 32'h0);
      i_host_bus_model.wr(CMD_FLAGS_WR, ~(32'h1 << BITPOS[k % 5]));
      rchk("flag keep", CMD_FLAGS_RD, 32'h1 << BITPOS[k % 5]);
      i_host_bus_model.wr(CMD_FLAGS_WR, 32'hffff_ffff);
      rchk("flag clr", CMD_FLAGS_RD, 32'h0);
    end
    check("sof tokens", sof_n, 32'h2);
    $display("test events done");
    @(negedge clk);
    schedule_overrun = 1'b1;
    repeat (3) @(negedge clk);
    schedule_overrun = 1'b0;
    soc = soc + 2'h3;
    rchk("count wrap", CMD_STATE_RD, {14'h0, soc, 16'h0});
    check("count port", {30'h0, overrun_count}, {30'h0, soc});
    i_host_bus_model.wr(CMD_FLAGS_WR, 32'hffff_ffff);
    resume_state_sw = 1'b1;
    ev(2);
    resume_state_sw = 1'b0;
    rchk("sw resume", CMD_FLAGS_RD, 32'h0);
    device_resume = 1'b1;
    repeat (3) @(negedge clk);
    i_host_bus_model.wr(CMD_FLAGS_WR, 32'hffff_ffff);
    frame_index[3:0] = 4'hf;
    repeat (3) @(negedge clk);
    device_resume = 1'b0;
    rchk("level resume", CMD_FLAGS_RD, 32'h0);
    // Event and clear taken at one edge: the event must survive
    fork
      i_host_bus_model.wr(CMD_FLAGS_WR, 32'hffff_ffff);
      ev(3);
    join
    rchk("set wins", CMD_FLAGS_RD, 32'h4);
    i_host_bus_model.wr(CMD_FLAGS_WR, 32'h4);
    rchk("set wins clr", CMD_FLAGS_RD, 32'h0);
    $display("test count and resume done");
    i_host_bus_model.wr(CMD_MASK_WR, 32'h8000_0000);
    ev(4);
    check("irq no enable", {31'h0, irq_req}, 32'h0);
    i_host_bus_model.wr(CMD_MASK_WR, 32'h1);
    check("irq on", {31'h0, irq_req}, 32'h1);
    i_host_bus_model.wr(CMD_MASK_CLR_WR, 32'h8000_0000);
    check("irq gate off", {31'h0, irq_req}, 32'h0);
    i_host_bus_model.wr(CMD_MASK_WR, 32'h8000_0000);
    check("irq again", {31'h0, irq_req}, 32'h1);
    i_host_bus_model.wr(CMD_FLAGS_WR, 32'h1);
    check("irq cleared", {31'h0, irq_req}, 32'h0);
    check("count irq", {30'h0, overrun_count}, {30'h0, soc});
    $display("test irq done");
    print_verdict();
  end
endmodule
`default_nettype wire
